/* sdr_decimator.sv */
`timescale 1ns/1ps
// Summary of operation
// - Modulator and filter run at half clock.
// - Three-bit field sets the decimation ratio.
// - Eight ratios, powers of two 128..16384.
// - Three power modes with nominal master clocks.
// - Output rate scales with clock and ratio.
// - No conversion data before reference settles.
// - Clock from input or crystal; oscillator off.
// - Linear-phase sinc FIR averages and downsamples.
// - Filter input is one-bit ones-density stream.
// - First two conversions fast, then sinc3.
// - Ratios above 1024 use sinc3 plus sinc1.
module sdr_decimator (
  // Clock and reset.
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // Configuration and status from the analog side.
  input  wire sdr_pkg::sdr_cfg_t i_cfg,
  input  wire logic             i_ref_settled,
  // Modulator bit, sampled on o_mod_clk_en.
  input  wire logic             i_mod_bit,
  // Clocking outputs.
  output logic                  o_mod_clk_en,
  output logic                  o_osc_enable,
  output sdr_pkg::sdr_mode_t    o_power_mode,
  output logic [15:0]           o_nominal_clk_khz,
  // Conversion results.
  output logic                  o_sample_valid,
  output sdr_pkg::sdr_sample_t  o_sample
);

  logic                      ref_ok;     // Reference has settled.
  logic                      mod_phase;  // Divider phase.
  logic                      mod_en;     // One modulator sample.
  logic [2:0]                sel_q;      // Ratio code in use.
  logic                      restart;    // Ratio code changed.
  logic [3:0]                ratio_log2; // Overall ratio exponent.
  logic [3:0]                s3_log2;    // Sinc3 ratio exponent.
  logic [3:0]                m_log2;     // Sinc1 ratio exponent.
  logic [9:0]                s3_cnt;     // Samples in sinc3 window.
  logic [3:0]                m_cnt;      // Sinc3 outputs in sinc1.
  logic                      s3_dump;    // Sinc3 decimation instant.
  logic                      conv_end;   // Conversion boundary.
  logic [sdr_pkg::ACC_W-1:0] int1;       // First integrator.
  logic [sdr_pkg::ACC_W-1:0] int2;       // Second integrator.
  logic [sdr_pkg::ACC_W-1:0] int3;       // Third integrator.
  logic [sdr_pkg::ACC_W-1:0] dly1;       // Comb delays.
  logic [sdr_pkg::ACC_W-1:0] dly2;
  logic [sdr_pkg::ACC_W-1:0] dly3;
  logic [sdr_pkg::ACC_W-1:0] comb1;      // Comb outputs.
  logic [sdr_pkg::ACC_W-1:0] comb2;
  logic [sdr_pkg::ACC_W-1:0] comb3;
  logic [sdr_pkg::SUM_W-1:0] s1_acc;     // Sinc1 running sum.
  logic [sdr_pkg::SUM_W-1:0] conv_sum;   // Finished sinc3+sinc1 sum.
  logic [14:0]               fast_cnt;   // Fast path ones count.
  logic [14:0]               fast_sum;   // Count including this bit.
  logic [1:0]                fast_left;  // Fast conversions left.
  logic [5:0]                sh_slow;    // Normalising shifts.
  logic [5:0]                sh_fast;
  logic [sdr_pkg::SUM_W-1:0] norm;       // Normalised result.

  // The reference must settle before anything is converted.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ref_ok <= 1'b0;
    end else if (i_ref_settled) begin
      ref_ok <= 1'b1;
    end
  end

  // Divide by two to give the modulator sample enable.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mod_phase <= 1'b0;
    end else if (ref_ok) begin
      mod_phase <= ~mod_phase;
    end
  end

  assign mod_en       = ref_ok & mod_phase;
  assign o_mod_clk_en = mod_en;
  // Ratio decode: code n selects two to the power of n plus seven.
  always_comb begin
    ratio_log2 = sdr_pkg::RATIO_MIN_LOG2
               + {1'b0, i_cfg.decimation_ratio_select};
    if (ratio_log2 > sdr_pkg::SINC3_MAX_LOG2) begin
      s3_log2 = sdr_pkg::SINC3_MAX_LOG2;
    end else begin
      s3_log2 = ratio_log2;
    end
    m_log2 = ratio_log2 - s3_log2;
  end

  // A ratio change restarts the filter windows from empty.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sel_q <= 3'h0;
    end else begin
      sel_q <= i_cfg.decimation_ratio_select;
    end
  end

  assign restart  = sel_q != i_cfg.decimation_ratio_select;
  assign s3_dump  = mod_en
                  & (s3_cnt == 10'((11'h1 << s3_log2) - 11'h1));
  assign conv_end = s3_dump
                  & (m_cnt == 4'((5'h1 << m_log2) - 5'h1));

  // Window counters for the sinc3 and sinc1 stages.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s3_cnt <= 10'h0;
      m_cnt  <= 4'h0;
    end else if (restart) begin
      s3_cnt <= 10'h0;
      m_cnt  <= 4'h0;
    end else if (s3_dump) begin
      s3_cnt <= 10'h0;
      m_cnt  <= conv_end ? 4'h0 : m_cnt + 4'h1;
    end else if (mod_en) begin
      s3_cnt <= s3_cnt + 10'h1;
    end
  end

  // Sinc3 integrators; wrap-around arithmetic is exact for a CIC.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      int1 <= '0;
      int2 <= '0;
      int3 <= '0;
    end else if (restart) begin
      int1 <= '0;
      int2 <= '0;
      int3 <= '0;
    end else if (mod_en) begin
      int1 <= int1 + sdr_pkg::ACC_W'(i_mod_bit);
      int2 <= int2 + int1;
      int3 <= int3 + int2;
    end
  end

  // Combs run once per sinc3 window.
  assign comb1 = int3 - dly1;
  assign comb2 = comb1 - dly2;
  assign comb3 = comb2 - dly3;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dly1 <= '0;
      dly2 <= '0;
      dly3 <= '0;
    end else if (restart) begin
      dly1 <= '0;
      dly2 <= '0;
      dly3 <= '0;
    end else if (s3_dump) begin
      dly1 <= int3;
      dly2 <= comb1;
      dly3 <= comb2;
    end
  end

  // Sinc1 stage sums sinc3 outputs over the remaining factor.
  assign conv_sum = s1_acc + sdr_pkg::SUM_W'(comb3);
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_acc <= '0;
    end else if (restart || conv_end) begin
      s1_acc <= '0;
    end else if (s3_dump) begin
      s1_acc <= conv_sum;
    end
  end

  // Fast-settling path: plain ones count over the whole ratio.
  assign fast_sum = fast_cnt + 15'(i_mod_bit);
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fast_cnt <= 15'h0;
    end else if (restart || conv_end) begin
      fast_cnt <= 15'h0;
    end else if (mod_en) begin
      fast_cnt <= fast_sum;
    end
  end

  // Path choice is permanent until the next reset.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fast_left <= sdr_pkg::FAST_CONV;
    end else if (conv_end && !restart && fast_left != 2'h0) begin
      fast_left <= fast_left - 2'h1;
    end
  end

  // Scale either path so that all ones reads as the same full scale.
  always_comb begin
    sh_slow = sdr_pkg::NORM_LOG2 - 6'({s3_log2, 1'b0} + s3_log2)
            - 6'(m_log2);
    sh_fast = sdr_pkg::NORM_LOG2 - 6'(ratio_log2);
    if (fast_left != 2'h0) begin
      norm = sdr_pkg::SUM_W'(fast_sum) << sh_fast;
    end else begin
      norm = conv_sum << sh_slow;
    end
  end

  // Result register, loaded once per conversion.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sample_valid <= 1'b0;
      o_sample       <= '0;
    end else begin
      o_sample_valid <= conv_end & ~restart;
      if (conv_end && !restart) begin
        o_sample.data <= norm[sdr_pkg::SUM_W-1 -: sdr_pkg::OUT_W];
        o_sample.fast <= fast_left != 2'h0;
      end
    end
  end

  // Clock source and power mode decode.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_osc_enable      <= 1'b0;
      o_power_mode      <= sdr_pkg::SDR_MODE_VERY_LOW;
      o_nominal_clk_khz <= sdr_pkg::CLK_VERY_LOW_KHZ;
    end else begin
      o_osc_enable <= i_cfg.use_crystal;
      o_power_mode <= i_cfg.power_mode_select;
      case (i_cfg.power_mode_select)
        sdr_pkg::SDR_MODE_HIGH_RES: begin
          o_nominal_clk_khz <= sdr_pkg::CLK_HIGH_RES_KHZ;
        end
        sdr_pkg::SDR_MODE_LOW: begin
          o_nominal_clk_khz <= sdr_pkg::CLK_LOW_KHZ;
        end
        default: begin
          o_nominal_clk_khz <= sdr_pkg::CLK_VERY_LOW_KHZ;
        end
      endcase
    end
  end

  // Helper for the checks: modulator samples since the last boundary.
  logic [14:0] chk_cnt;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      chk_cnt <= 15'h0;
    end else if (restart || conv_end) begin
      chk_cnt <= 15'h0;
    end else if (mod_en) begin
      chk_cnt <= chk_cnt + 15'h1;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  chk_mod_half_rate: assert property (
    mod_en |=> !mod_en ##1 mod_en)
    else $error("Modulator enable is not half rate.");
  chk_no_early_data: assert property (
    !ref_ok |-> !o_sample_valid && !mod_en)
    else $error("Data before reference settled.");
  chk_ratio_window: assert property (
    conv_end && !restart |->
      chk_cnt == 15'((16'h1 << ratio_log2) - 16'h1))
    else $error("Conversion window differs from ratio.");
  chk_fast_first: assert property (
    conv_end && !restart && fast_left != 2'h0 |=>
      o_sample_valid && o_sample.fast)
    else $error("Early conversion not from fast path.");
  chk_sinc3_after: assert property (
    conv_end && !restart && fast_left == 2'h0 |=>
      o_sample_valid && !o_sample.fast)
    else $error("Late conversion not from sinc3 path.");
  chk_split_ratio: assert property (
    ratio_log2 > sdr_pkg::SINC3_MAX_LOG2 |->
      s3_log2 == sdr_pkg::SINC3_MAX_LOG2 && m_log2 == ratio_log2 - 4'ha)
    else $error("Sinc3 and sinc1 split is wrong.");
  chk_valid_pulse: assert property (
    o_sample_valid |=> !o_sample_valid [*8])
    else $error("Samples come faster than any ratio allows.");
  chk_osc_off: assert property (
    !i_cfg.use_crystal ##1 !i_cfg.use_crystal |-> !o_osc_enable)
    else $error("Oscillator left on while unused.");
  chk_high_res_clock: assert property (
    o_power_mode == sdr_pkg::SDR_MODE_HIGH_RES |->
      o_nominal_clk_khz == sdr_pkg::CLK_HIGH_RES_KHZ)
    else $error("High-resolution nominal clock wrong.");
  cov_fast_sample: cover property (o_sample_valid && o_sample.fast);
  cov_sinc3_sample: cover property (o_sample_valid && !o_sample.fast);
  cov_split_path: cover property (conv_end && m_log2 == 4'h4);

endmodule

/* sdr_pkg.sv */
package sdr_pkg;

  // Power modes; the two-bit codes are our own assignment.
  typedef enum logic [1:0] {
    SDR_MODE_VERY_LOW = 2'h0,
    SDR_MODE_LOW      = 2'h1,
    SDR_MODE_HIGH_RES = 2'h2,
    SDR_MODE_RSVD     = 2'h3
  } sdr_mode_t;

  // Configuration word driven by the surrounding control logic.
  typedef struct packed {
    logic [2:0] decimation_ratio_select; // Ratio code, 0 is 128.
    sdr_mode_t  power_mode_select;       // Power mode.
    logic       use_crystal;             // Crystal oscillator is source.
  } sdr_cfg_t;

  // Output width of a conversion result.
  localparam int unsigned OUT_W = 24;

  // One conversion result with the filter path that produced it.
  typedef struct packed {
    logic [OUT_W-1:0] data; // Ones density, 0x800000 is all ones.
    logic             fast; // Result came from the fast-settling path.
  } sdr_sample_t;

  // Modulator rate is the master clock divided by this.
  localparam int unsigned MOD_DIV       = 2;
  // Smallest ratio is two to this power.
  localparam logic [3:0]  RATIO_MIN_LOG2 = 4'h7;
  // Largest ratio the sinc3 stage runs at, as a power of two.
  localparam logic [3:0]  SINC3_MAX_LOG2 = 4'ha;
  // Conversions taken from the fast-settling path after reset.
  localparam logic [1:0]  FAST_CONV     = 2'h2;
  // Accumulator widths of the sinc3 stage and of the full path.
  localparam int unsigned ACC_W         = 31;
  localparam int unsigned SUM_W         = 35;
  // Full scale of the normalised sum, as a power of two.
  localparam logic [5:0]  NORM_LOG2     = 6'h22;
  // Nominal master clocks in kHz for each power mode.
  localparam logic [15:0] CLK_HIGH_RES_KHZ = 16'h2000;
  localparam logic [15:0] CLK_LOW_KHZ      = 16'h1000;
  localparam logic [15:0] CLK_VERY_LOW_KHZ = 16'h0800;

endpackage

/* sdr_host_model.sv */
`timescale 1ns/1ps
// Modulator bit source and host that counts the results it reads.
module sdr_host_model (
  // Clock and reset.
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  // Stream pattern: 0 zeros, 1 ones, 2 alternating.
  input  wire logic [1:0]           i_pattern,
  // Device side.
  input  wire logic                 i_mod_clk_en,
  input  wire logic                 i_sample_valid,
  input  wire sdr_pkg::sdr_sample_t i_sample,
  output logic                      o_mod_bit,
  output int                        o_count
);
  logic phase; // Alternating bit, flips after each taken bit.
  // Advance only where the device takes a bit, so windows stay exact.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) phase <= 1'b1;
    else if (i_mod_clk_en) phase <= ~phase;
  end
  // One-bit ones-density stream for the filter.
  assign o_mod_bit = (i_pattern == 2'h2) ? phase : i_pattern[0];
  // The host reads each result in the one cycle it is flagged.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) o_count <= 0;
    else if (i_sample_valid) o_count <= o_count + 1;
  end
endmodule

/* sdr_decimator_tb.sv */
`timescale 1ns/1ps
module sdr_decimator_tb;
  logic                 i_clk = 1'b0; // Master clock from the host.
  logic                 i_rst = 1'b1;
  sdr_pkg::sdr_cfg_t    cfg   = '0;
  logic                 ref_ok = 1'b0;
  logic [1:0]           pat   = 2'h2;
  logic                 mbit, men, osc, sv;
  sdr_pkg::sdr_mode_t   pm;
  logic [15:0]          khz;
  sdr_pkg::sdr_sample_t smp;
  int                   hcnt;
  int                   bad_count = 0;
  int                   n_compared = 0;
  int                   cyc;
  // One fixed clock stands for every mode's nominal clock.
  always #4 i_clk = ~i_clk;
  sdr_decimator u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_cfg(cfg),
    .i_ref_settled(ref_ok), .i_mod_bit(mbit), .o_mod_clk_en(men),
    .o_osc_enable(osc), .o_power_mode(pm), .o_nominal_clk_khz(khz),
    .o_sample_valid(sv), .o_sample(smp));
  sdr_host_model u_host (.i_clk(i_clk), .i_rst(i_rst), .i_pattern(pat),
    .i_mod_clk_en(men), .i_sample_valid(sv), .i_sample(smp),
    .o_mod_bit(mbit), .o_count(hcnt));
  // Records one comparison and reports a mismatch.
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  // Inputs always change 1 ns after the rising edge.
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // Counts cycles until a result is flagged, bounded by lim.
  task automatic wait_valid(input int lim);
    cyc = 0;
    while (sv !== 1'b1 && cyc < lim) begin
      tick(1);
      cyc++;
    end
    chk(sv === 1'b1, "no result in time");
  endtask
  // Outputs idle in reset and no activity before the reference settles.
  task automatic t_reset();
    logic quiet;
    quiet = 1'b1;
    tick(3);
    chk(pm === sdr_pkg::SDR_MODE_VERY_LOW
        && khz === sdr_pkg::CLK_VERY_LOW_KHZ, "reset");
    i_rst = 1'b0;
    repeat (40) begin
      tick(1);
      if (men !== 1'b0 || sv !== 1'b0) quiet = 1'b0;
    end
    chk(quiet, "activity before reference");
    ref_ok = 1'b1;
  endtask
  // The bit strobe alternates, one bit every second clock.
  task automatic t_modclk();
    int k;
    k = 0;
    while (men !== 1'b1 && k < 8) begin
      tick(1);
      k++;
    end
    for (int i = 0; i < 8; i++) begin
      chk(men === (i % 2 == 0), "bit strobe");
      tick(1);
    end
  endtask
  // Two fast conversions, then the sinc3 path; window of 128 bits.
  task automatic t_fast();
    wait_valid(300);
    chk(smp.fast === 1'b1 && smp.data === 24'h400000, "half");
    pat = 2'h1;
    tick(1);
    wait_valid(300);
    chk(cyc === 255, "spacing 128");
    chk(smp.fast === 1'b1 && smp.data === 24'h800000, "ones");
    for (int i = 3; i <= 5; i++) begin
      tick(1);
      wait_valid(300);
      chk(smp.fast === 1'b0, "path");
    end
    chk(smp.data === 24'h800000, "sinc3 ones");
    pat = 2'h0;
    repeat (4) begin
      tick(1);
      wait_valid(300);
    end
    chk(smp.data === 24'h000000, "sinc3 zeros");
  endtask
  // Power modes, nominal clocks and oscillator enable.
  task automatic t_cfg();
    logic [15:0] e;
    for (int m = 0; m < 4; m++) begin
      cfg.power_mode_select = sdr_pkg::sdr_mode_t'(m);
      cfg.use_crystal = m[0];
      tick(2);
      e = (m == 2) ? sdr_pkg::CLK_HIGH_RES_KHZ :
          (m == 1) ? sdr_pkg::CLK_LOW_KHZ : sdr_pkg::CLK_VERY_LOW_KHZ;
      chk(pm === cfg.power_mode_select && khz === e, "mode");
      chk(osc === m[0], "oscillator");
    end
  endtask
  // Ratio codes 1 to 7 each restart the window; result after 2*N clocks.
  task automatic t_ratio();
    int n;
    for (int c = 1; c < 8; c++) begin
      n = 2 << (7 + c);
      cfg.decimation_ratio_select = 3'(c);
      tick(1);
      wait_valid(n + 8);
      chk(cyc >= n - 4 && cyc <= n + 3, "ratio");
      chk(smp.fast === 1'b0, "path kept");
      if (c == 4) begin
        tick(1);
        wait_valid(n + 8);
        chk(cyc === n - 1, "spacing 2048");
      end
    end
  endtask
  // A second reset brings back the fast path.
  task automatic t_rerst();
    i_rst = 1'b1;
    tick(3);
    chk(sv === 1'b0 && hcnt === 0, "second reset");
    i_rst = 1'b0;
    cfg.decimation_ratio_select = 3'h0;
    wait_valid(400);
    chk(smp.fast === 1'b1, "fast after reset");
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence.
  initial begin
    t_reset();
    t_modclk();
    t_fast();
    t_cfg();
    t_ratio();
    t_rerst();
    end_of_test();
  end
  // Watchdog: the tests need about 72000 cycles.
  initial begin
    #(90000 * 8);
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test();
  end
endmodule
